// >>> hdl/sensor_spi_map.vh
// Constants for the sensor serial slave port: register offsets, field positions, reset values, timing counts.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef SENSOR_SPI_MAP_VH
`define SENSOR_SPI_MAP_VH

// Address byte layout.
`define DIR_BIT             7
`define ADDR_MSB            6
// Register offsets.
`define REG_MOTION          7'h02
`define REG_FW_LOAD_CTRL    7'h14
`define REG_MOTION_BURST    7'h50
`define REG_FW_LOAD_DATA    7'h60
// Firmware load control values and reset value.
`define FW_STEP_ONE         8'h1d
`define FW_STEP_TWO         8'h18
`define FW_CTRL_RESET       8'h00
// Motion burst length in bytes (64 bits).
`define BURST_BYTES         4'h8
// Burst exit hold: 4 us is 200 cycles of the 50 MHz core clock, sized to the exit counter.
`define BURST_EXIT_CYCLES   13'h00c8

`endif

// >>> hdl/pin_sync.v
// Two-stage synchroniser for a group of pins from outside the core clock domain.
// Assumes the pins are asynchronous levels; output is safe for logic on core_clk.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset.
  input  wire             core_clk,
  input  wire             rst,
  // Pins in, synchronised levels out.
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out
);

  reg [WIDTH-1:0] stage_one_reg;

  // The first stage is read only by the second.
  always @(posedge core_clk) begin
    if (rst) begin
      stage_one_reg <= {WIDTH{1'b1}};
      pin_out       <= {WIDTH{1'b1}};
    end else begin
      stage_one_reg <= pin_in;
      pin_out       <= stage_one_reg;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/byte_shifter.v
// Eight-bit serial shifter: takes in one bit per sample strobe, shifts out one bit per launch strobe.
// Assumes strobes come from the same clock; most significant bit first both ways.
`timescale 1ns/100ps
`default_nettype none

module byte_shifter (
  // Clock and clear.
  input  wire       core_clk,
  input  wire       clear,
  // Receive side.
  input  wire       sample,
  input  wire       bit_in,
  output reg  [7:0] rx_reg,
  output reg  [2:0] rx_count_reg,
  // Transmit side.
  input  wire       load,
  input  wire [7:0] load_data,
  input  wire       launch,
  output reg        bit_out_reg
);

  reg [7:0] tx_reg;

  // Receive: the byte completes when the count wraps.
  always @(posedge core_clk) begin
    if (clear) begin
      rx_reg       <= 8'h00;
      rx_count_reg <= 3'h0;
    end else if (sample) begin
      rx_reg       <= {rx_reg[6:0], bit_in};
      rx_count_reg <= rx_count_reg + 3'h1;
    end
  end

  // Transmit: a launch puts out the next bit and holds it until the next launch.
  always @(posedge core_clk) begin
    if (clear) begin
      tx_reg      <= 8'h00;
      bit_out_reg <= 1'b0;
    end else if (load) begin
      tx_reg      <= load_data;
    end else if (launch) begin
      bit_out_reg <= tx_reg[7];
      tx_reg      <= {tx_reg[6:0], 1'b0};
    end
  end

endmodule
`default_nettype wire

// >>> hdl/sensor_spi_slave_port.v
// Serial slave port of the motion sensor: framing, writes, reads and the motion burst.
// Assumes link pins are asynchronous; register contents are inputs from the sensor core.
`timescale 1ns/100ps
`default_nettype none
`include "sensor_spi_map.vh"

module sensor_spi_slave_port (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst,
  // Serial link pins.
  input  wire        serial_clk,
  input  wire        host_data_in,
  input  wire        select_line_n,
  input  wire        power_down_in_n,
  output wire        dev_data_out,
  output wire        dev_data_oe_n,
  // Pull-up enable towards the pads.
  input  wire        pullup_select,
  output wire        pullup_en,
  // Register access towards the sensor core.
  output reg  [6:0]  reg_addr_reg,
  output reg         reg_write_stb_reg,
  output reg  [7:0]  reg_wdata_reg,
  input  wire [7:0]  reg_rdata,
  // Motion snapshot from the sensor core.
  input  wire [7:0]  motion_flags,
  input  wire [7:0]  x_displacement,
  input  wire [7:0]  y_displacement,
  input  wire [7:0]  surface_quality,
  input  wire [7:0]  exposure_high_byte,
  input  wire [7:0]  exposure_low_byte,
  input  wire [7:0]  peak_pixel_value,
  // Status.
  output reg  [7:0]  firmware_load_control_reg,
  output reg         firmware_load_armed_reg,
  output wire        burst_active
);

  // Port states.
  localparam [2:0] ST_ADDR   = 3'h0;
  localparam [2:0] ST_WDATA  = 3'h1;
  localparam [2:0] ST_RDATA  = 3'h2;
  localparam [2:0] ST_MBURST = 3'h3;
  localparam [2:0] ST_FBURST = 3'h4;
  localparam [2:0] ST_LOCKED = 3'h5;

  localparam [12:0] EXIT_CYCLES = `BURST_EXIT_CYCLES;

  wire [2:0] pins_sync;
  wire       sclk_s;
  wire       mosi_s;
  wire       sel_n_s;
  reg        sclk_prev_reg;
  reg        npd_s1_reg;
  reg        npd_s2_reg;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [55:0] burst_buf_reg;
  reg  [3:0] burst_count_reg;
  reg  [12:0] exit_count_reg;
  reg        exit_done_reg;
  wire       port_enable;
  wire       rise;
  wire       fall;
  wire       abort;
  wire [7:0] rx_byte;
  wire [2:0] rx_count;
  wire [7:0] rx_full;
  wire       byte_done;
  wire       tx_bit;
  reg        load;
  reg  [7:0] load_data;

  // Synchronise clock, data and select before any logic reads them.
  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   ({serial_clk, host_data_in, select_line_n}),
    .pin_out  (pins_sync)
  );

  assign sclk_s  = pins_sync[2];
  assign mosi_s  = pins_sync[1];
  assign sel_n_s = pins_sync[0];

  // Power-down pin is synchronised locally.
  always @(posedge core_clk) begin
    if (rst) begin
      npd_s1_reg <= 1'b0;
      npd_s2_reg <= 1'b0;
    end else begin
      npd_s1_reg <= power_down_in_n;
      npd_s2_reg <= npd_s1_reg;
    end
  end

  // The port is live only out of reset, out of power down and while selected.
  assign port_enable = npd_s2_reg & ~rst & ~sel_n_s;
  assign abort       = ~port_enable;

  // Clock edge detection on the synchronised serial clock.
  always @(posedge core_clk) begin
    if (rst) begin
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  assign rise = port_enable & sclk_s & ~sclk_prev_reg;
  assign fall = port_enable & ~sclk_s & sclk_prev_reg;

  // Received byte including the bit being sampled now.
  assign rx_full   = {rx_byte[6:0], mosi_s};
  assign byte_done = rise & (rx_count == 3'h7);

  byte_shifter u_shift (
    .core_clk     (core_clk),
    .clear        (abort),
    .sample       (rise),
    .bit_in       (mosi_s),
    .rx_reg       (rx_byte),
    .rx_count_reg (rx_count),
    .load         (load),
    .load_data    (load_data),
    .launch       (fall & (state_reg == ST_RDATA || state_reg == ST_MBURST)),
    .bit_out_reg  (tx_bit)
  );

  // Output is driven only while selected and sending; the host only ever clocks it out.
  assign dev_data_out  = tx_bit;
  assign dev_data_oe_n = ~(port_enable & (state_reg == ST_RDATA || state_reg == ST_MBURST));
  assign pullup_en     = pullup_select & ~rst;
  assign burst_active  = (state_reg == ST_MBURST) || (state_reg == ST_FBURST) || (state_reg == ST_LOCKED);

  // Byte-level state machine.
  always @* begin
    state_next = state_reg;
    load       = 1'b0;
    load_data  = 8'h00;
    case (state_reg)
      ST_ADDR: begin
        if (byte_done) begin
          if (rx_full[`DIR_BIT]) begin
            state_next = ST_WDATA;
          end else if (rx_full[`ADDR_MSB:0] == `REG_MOTION_BURST) begin
            state_next = ST_MBURST;
            load       = 1'b1;
            load_data  = motion_flags;
          end else begin
            state_next = ST_RDATA;
          end
        end
      end
      ST_WDATA: begin
        if (byte_done) begin
          if (reg_addr_reg == `REG_FW_LOAD_DATA && firmware_load_armed_reg) begin
            state_next = ST_FBURST;
          end else begin
            state_next = ST_ADDR;
          end
        end
      end
      ST_RDATA: begin
        // Data is fetched only while the clock pauses high, so the first fall launches and never reloads.
        if (byte_done) begin
          state_next = ST_ADDR;
        end else if (rx_count == 3'h0 && sclk_s && !rise) begin
          load      = 1'b1;
          load_data = reg_rdata;
        end
      end
      ST_MBURST: begin
        if (byte_done) begin
          if (burst_count_reg == `BURST_BYTES - 4'h1) begin
            state_next = ST_LOCKED;
          end else begin
            load      = 1'b1;
            load_data = burst_buf_reg[55:48];
          end
        end
      end
      ST_FBURST: begin
        state_next = ST_FBURST; // Firmware bytes stream until a long enough deselect.
      end
      ST_LOCKED: begin
        state_next = ST_LOCKED;
      end
      default: begin
        state_next = ST_ADDR;
      end
    endcase
  end

  // State register; deselect returns to idle, a burst needs a long enough deselect.
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_ADDR;
    end else if (abort) begin
      if (!burst_active || exit_done_reg) begin
        state_reg <= ST_ADDR;
      end
    end else if (burst_active && !exit_done_reg && state_reg != ST_MBURST && state_reg != ST_FBURST) begin
      state_reg <= ST_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  // Deselect timer for leaving burst mode.
  always @(posedge core_clk) begin
    if (rst) begin
      exit_count_reg <= 13'h0000;
      exit_done_reg  <= 1'b0;
    end else if (!sel_n_s) begin
      exit_count_reg <= 13'h0000;
      if (state_reg == ST_ADDR) begin
        exit_done_reg <= 1'b0;
      end
    end else if (exit_count_reg == EXIT_CYCLES - 13'h0001) begin
      exit_done_reg <= 1'b1;
    end else begin
      exit_count_reg <= exit_count_reg + 13'h0001;
    end
  end

  // Burst buffer: snapshot taken when the burst address completes.
  always @(posedge core_clk) begin
    if (rst) begin
      burst_buf_reg   <= 56'h0;
      burst_count_reg <= 4'h0;
    end else if (state_reg == ST_ADDR && state_next == ST_MBURST && !abort) begin
      burst_buf_reg   <= {x_displacement, y_displacement, surface_quality, exposure_high_byte,
                          exposure_low_byte, peak_pixel_value, 8'h00};
      burst_count_reg <= 4'h0;
    end else if (state_reg == ST_MBURST && byte_done && !abort) begin
      burst_buf_reg   <= {burst_buf_reg[47:0], 8'h00};
      burst_count_reg <= burst_count_reg + 4'h1;
    end
  end

  // Register address, write strobe and write data.
  always @(posedge core_clk) begin
    if (rst) begin
      reg_addr_reg      <= 7'h00;
      reg_wdata_reg     <= 8'h00;
      reg_write_stb_reg <= 1'b0;
    end else begin
      reg_write_stb_reg <= 1'b0;
      if (!abort && state_reg == ST_ADDR && byte_done) begin
        reg_addr_reg <= rx_full[`ADDR_MSB:0];
      end
      if (!abort && byte_done && (state_reg == ST_WDATA || state_reg == ST_FBURST)) begin
        reg_wdata_reg     <= rx_full;
        reg_write_stb_reg <= 1'b1;
      end
    end
  end

  // Firmware load control register and its arming sequence.
  always @(posedge core_clk) begin
    if (rst) begin
      firmware_load_control_reg <= `FW_CTRL_RESET;
      firmware_load_armed_reg   <= 1'b0;
    end else if (!abort && byte_done && state_reg == ST_WDATA && reg_addr_reg == `REG_FW_LOAD_CTRL) begin
      firmware_load_control_reg <= rx_full;
      if (rx_full == `FW_STEP_TWO && firmware_load_control_reg == `FW_STEP_ONE) begin
        firmware_load_armed_reg <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> test/host_spi_model.sv
// Host master model for the sensor serial port: framing and byte clocking.
// Assumes a 160 ns serial clock that stands high outside frames.
`timescale 1ns/100ps
`default_nettype none

module host_spi_model (
  // Pins towards the port.
  output var logic serial_clk,
  output var logic host_data_in,
  output var logic select_line_n,
  // Pins from the port.
  input  wire logic dev_data_out,
  input  wire logic dev_data_oe_n
);
  // Idle link: clock high, port deselected.
  initial begin
    serial_clk = 1'b1;
    host_data_in = 1'b1;
    select_line_n = 1'b1;
  end

  // Frames each transaction; a released data line flips so no stale level survives.
  task automatic frame(input logic lvl);
    if (lvl)
      #120;
    select_line_n <= lvl;
    if (lvl)
      host_data_in <= ~host_data_in;
    #200;
  endtask

  // Clocks one byte MSB first; data is set on the fall and read early in the high phase.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_clk <= 1'b0;
      host_data_in <= tx[i];
      #80 serial_clk <= 1'b1;
      // Sample between core edges, before the port reacts to this rising edge.
      #10 rx[i] = dev_data_oe_n ? 1'bx : dev_data_out;
      #70;
    end
  endtask
endmodule
`default_nettype wire

// >>> test/sensor_spi_slave_port_assertions.sv
// Checker for the sensor serial port, bound to the top module.
// Assumes the synchronous active-high reset and 50 MHz core clock.
`timescale 1ns/100ps
`default_nettype none

module sensor_spi_checker (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rst,
  // Link pins.
  input wire logic       serial_clk,
  input wire logic       select_line_n,
  input wire logic       power_down_in_n,
  input wire logic       dev_data_out,
  input wire logic       dev_data_oe_n,
  // Register side and status.
  input wire logic       reg_write_stb_reg,
  input wire logic [6:0] reg_addr_reg,
  input wire logic [7:0] reg_wdata_reg,
  input wire logic [7:0] firmware_load_control_reg,
  input wire logic       firmware_load_armed_reg,
  input wire logic       burst_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Select levels held long enough to pass the pin synchroniser.
  sequence sel_low;
    !select_line_n [*3];
  endsequence
  sequence sel_high;
    select_line_n [*6];
  endsequence

  AST_DESEL_TRISTATE: assert property (sel_high |-> dev_data_oe_n)
    else $error("output driven while deselected");
  AST_DESEL_NO_WRITE: assert property (sel_high |-> !reg_write_stb_reg)
    else $error("write strobe while deselected");
  AST_RESET_IDLE: assert property ($fell(rst) |-> dev_data_oe_n && !reg_write_stb_reg && firmware_load_control_reg == 8'h00)
    else $error("port not idle after reset");
  AST_PD_IDLE: assert property (!power_down_in_n [*5] |-> dev_data_oe_n && !reg_write_stb_reg)
    else $error("port active in power down");
  AST_STB_ONE: assert property (reg_write_stb_reg |=> !reg_write_stb_reg)
    else $error("write strobe longer than one cycle");
  AST_OUT_ON_FALL: assert property (!dev_data_oe_n && $past(!dev_data_oe_n) && $changed(dev_data_out)
    |-> !$past(serial_clk, 3) || !$past(serial_clk, 4) || !$past(serial_clk, 5))
    else $error("output bit changed away from a falling clock");
  AST_CTRL_WRITE: assert property (reg_write_stb_reg && reg_addr_reg == 7'h14
    |-> ##[0:2] firmware_load_control_reg == reg_wdata_reg)
    else $error("control register missed a write");
  AST_ARM_ORDER: assert property ($rose(firmware_load_armed_reg) |-> firmware_load_control_reg == 8'h18)
    else $error("armed without second step value");
  AST_BURST_HOLD: assert property (sel_low ##0 burst_active |=> burst_active)
    else $error("burst left while selected");
endmodule

bind sensor_spi_slave_port sensor_spi_checker u_chk (
  .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .select_line_n(select_line_n),
  .power_down_in_n(power_down_in_n), .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n),
  .reg_write_stb_reg(reg_write_stb_reg), .reg_addr_reg(reg_addr_reg), .reg_wdata_reg(reg_wdata_reg),
  .firmware_load_control_reg(firmware_load_control_reg),
  .firmware_load_armed_reg(firmware_load_armed_reg), .burst_active(burst_active)
);
`default_nettype wire

// >>> test/sensor_spi_slave_port_tb.sv
// Testbench for the sensor serial port: host model, checker and scenarios.
// Assumes a 50 MHz core clock and a 160 ns serial clock.
`timescale 1ns/100ps
`default_nettype none

module sensor_spi_slave_port_tb;
  logic       core_clk, rst, power_down_in_n, pullup_select;
  logic [7:0] reg_rdata;
  logic [7:0] mot [0:6];
  wire        serial_clk, host_data_in, select_line_n, dev_data_out, dev_data_oe_n, pullup_en;
  wire        reg_write_stb_reg, firmware_load_armed_reg, burst_active;
  wire  [6:0] reg_addr_reg;
  wire  [7:0] reg_wdata_reg, firmware_load_control_reg;
  int         error_cnt, checks, stb_cnt;

  host_spi_model host (.serial_clk(serial_clk), .host_data_in(host_data_in), .select_line_n(select_line_n),
    .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n));

  sensor_spi_slave_port DUT (.core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
    .host_data_in(host_data_in), .select_line_n(select_line_n), .power_down_in_n(power_down_in_n),
    .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n), .pullup_select(pullup_select),
    .pullup_en(pullup_en), .reg_addr_reg(reg_addr_reg), .reg_write_stb_reg(reg_write_stb_reg),
    .reg_wdata_reg(reg_wdata_reg), .reg_rdata(reg_rdata), .motion_flags(mot[0]), .x_displacement(mot[1]),
    .y_displacement(mot[2]), .surface_quality(mot[3]), .exposure_high_byte(mot[4]),
    .exposure_low_byte(mot[5]), .peak_pixel_value(mot[6]),
    .firmware_load_control_reg(firmware_load_control_reg),
    .firmware_load_armed_reg(firmware_load_armed_reg), .burst_active(burst_active));

  // Core clock, 20 ns period.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Counts write strobes seen from the port.
  always @(posedge core_clk)
    if (reg_write_stb_reg === 1'b1)
      stb_cnt <= stb_cnt + 1;

  // Compares one byte.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  // Compares one flag.
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // Ends the run with the verdict.
  task automatic tally_and_finish;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Two-byte write, then the host's write spacing.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame(1'b0);
    host.xfer({1'b1, a}, r);
    host.xfer(d, r);
    host.frame(1'b1);
    #50000;
  endtask

  // Read with an address-to-data pause.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] r;
    host.frame(1'b0);
    host.xfer({1'b0, a}, r);
    #50000;
    host.xfer(8'h00, d);
    host.frame(1'b1);
  endtask

  // Writes, firmware arming sequence, and two firmware bytes.
  task automatic t_write;
    logic [7:0] r;
    wr(7'h14, 8'h1d);
    chk8(stb_cnt[7:0], 8'h01);
    chk8({1'b0, reg_addr_reg}, 8'h14);
    chk8(reg_wdata_reg, 8'h1d);
    chk1(firmware_load_armed_reg, 1'b0);
    #200000;
    wr(7'h14, 8'h18);
    chk1(firmware_load_armed_reg, 1'b1);
    chk8(firmware_load_control_reg, 8'h18);
    // Armed: a write to the load data register streams bytes until a long deselect.
    host.frame(1'b0);
    host.xfer(8'he0, r);
    host.xfer(8'h3c, r);
    #10000;
    host.xfer(8'ha5, r);
    #1000;
    chk8(stb_cnt[7:0], 8'h04);
    chk8(reg_wdata_reg, 8'ha5);
    chk1(burst_active, 1'b1);
    host.frame(1'b1);
    #5000;
    chk1(burst_active, 1'b0);
  endtask

  // Ordinary read and two aborted writes, one cut by deselect and one made in power down.
  task automatic t_read_abort;
    logic [7:0] d;
    @(posedge core_clk) reg_rdata <= 8'hc5;
    rd(7'h05, d);
    chk8(d, 8'hc5);
    host.frame(1'b0);
    host.xfer(8'h94, d);
    host.frame(1'b1);
    #50000;
    chk8(stb_cnt[7:0], 8'h04);
    @(posedge core_clk) power_down_in_n <= 1'b0;
    wr(7'h14, 8'h00);
    chk8(stb_cnt[7:0], 8'h04);
    chk8(firmware_load_control_reg, 8'h18);
    @(posedge core_clk) power_down_in_n <= 1'b1;
  endtask

  // Motion burst: snapshot at address end, eight bytes, locked until deselected.
  task automatic t_burst;
    logic [7:0] d;
    host.frame(1'b0);
    host.xfer(8'h50, d);
    @(posedge core_clk) foreach (mot[i]) mot[i] <= 8'h00;
    #75000;
    for (int i = 0; i < 8; i++) begin
      host.xfer(8'h00, d);
      chk8(d, (i < 7) ? 8'h81 + 8'(i * 9) : 8'h00);
    end
    host.xfer(8'h94, d);
    host.xfer(8'h77, d);
    chk1(burst_active, 1'b1);
    chk8(stb_cnt[7:0], 8'h04);
    host.frame(1'b1);
    #5000;
    chk1(burst_active, 1'b0);
    chk1(dev_data_oe_n, 1'b1);
  endtask

  // Watchdog well past the expected run time.
  initial begin
    #1500000;
    error_cnt++;
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    power_down_in_n = 1'b1;
    pullup_select = 1'b1;
    reg_rdata = 8'h00;
    foreach (mot[i]) mot[i] = 8'h81 + 8'(i * 9);
    repeat (8) @(posedge core_clk);
    chk1(pullup_en, 1'b0);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk1(dev_data_oe_n, 1'b1);
    chk8(firmware_load_control_reg, 8'h00);
    chk1(pullup_en, 1'b1);
    pullup_select <= 1'b0;
    @(posedge core_clk);
    chk1(pullup_en, 1'b0);
    pullup_select <= 1'b1;
    @(posedge core_clk);
    t_write();
    t_read_abort();
    t_burst();
    tally_and_finish;
  end
endmodule
`default_nettype wire
